// >>> rtl/txdq_consts.vh
// Constants of the transmit descriptor queue manager
`ifndef TXDQ_CONSTS_VH
`define TXDQ_CONSTS_VH
// Register byte offsets
`define TXDQ_OFS_TBASE   8'h00
`define TXDQ_OFS_QBASE   8'h04
`define TXDQ_OFS_RQ_S    8'h08
`define TXDQ_OFS_RQ_W    8'h0C
`define TXDQ_OFS_RQ_R    8'h10
`define TXDQ_OFS_RQ_E    8'h14
`define TXDQ_OFS_FQ_S    8'h18
`define TXDQ_OFS_FQ_W    8'h1C
`define TXDQ_OFS_FQ_R    8'h20
`define TXDQ_OFS_FQ_E    8'h24
`define TXDQ_OFS_CTRL    8'h28
`define TXDQ_OFS_STAT    8'h2C
`define TXDQ_OFS_CHAN    8'h30
// Control fields
`define TXDQ_CTRL_CACHE  0
`define TXDQ_CTRL_FLUSH  1
// Channel config fields
`define TXDQ_CH_PRI      16
`define TXDQ_CH_ACT      17
`define TXDQ_CH_UF       18
// Status codes of a returned reference
`define TXDQ_ST_UNPROV   2'h2
// Free element: low three byte lanes only
`define TXDQ_FREE_SEL    4'h7
`define TXDQ_SEL_ALL     4'hF
// Element width
`define TXDQ_ELEM_W      18
`endif

// >>> rtl/txdq_top.v
// Transmit descriptor reference queue manager with Wishbone registers
//
// Local design decisions: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "txdq_consts.vh"
// Behaviour
// - descriptor address is table base plus sixteen times the 15-bit reference.
// - ready references come from the host queue; freed ones return to free queue.
// - up to six free references cached; with caching on, written in sixes.
// - completion-notify flushes the cache and sends that reference straight out.
// - software flush bit empties the cache and clears itself when done.
// - one shared queue base; 16-bit start, end, read, write indexes; offset is 4x.
// - read index marks last read slot; write index marks next free slot.
// - the end slot is never used; indexes wrap from end to start.
// - empty when read is one below write, or below end with write at start.
// - full when read equals write; then nothing more is written.
// - element carries 15-bit reference in low bits and 3-bit status above.
// - free element bits 23 to 18 written zero, bits 31 to 24 untouched.
// - no access to a descriptor after its reference is freed.
// - status 00 last, 01 partial, 10 unprovisioned, 11 malformed; bit 2 underflow.
// - other statuses stand for one descriptor and one buffer.
// - underflow reported once, on the channel's first available reference.
// - late underflow is reported on the next packet's first reference.
// - channel table caches per-channel state and pointers.
// - two table entries per channel, priority 1 and priority 0.
// - entry underflow flag set by downstream, cleared when a reference is freed.
// - entry active flag is 1 for provisioned, 0 for inactive channel.
module txdq_top #(
    parameter NUM_CHAN = 672,
    parameter CH_W     = 10,
    parameter CACHE_N  = 6
) (
    // Clock and reset
    input  wire        core_clk,
    input  wire        reset_n,
    // Wishbone register slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Host memory master
    output reg         mem_req_q,
    output reg         mem_we_q,
    output reg  [31:0] mem_addr_q,
    output reg  [3:0]  mem_sel_q,
    output reg  [31:0] mem_wdata_q,
    input  wire        mem_ack,
    input  wire [31:0] mem_rdata,
    // Ready references to the fetch engine
    output reg         rdy_valid_q,
    output reg  [14:0] rdy_descriptor_ref_q,
    output reg  [31:0] rdy_descriptor_address_q,
    input  wire        rdy_ready,
    // Finished references from the fetch engine
    input  wire        ret_valid,
    input  wire [14:0] ret_descriptor_ref,
    input  wire [1:0]  ret_status,
    input  wire [CH_W-1:0] ret_chan,
    input  wire        ret_pri,
    input  wire        ret_completion_notify_flag,
    output reg         ret_ready_q,
    // Underflow events from the downstream transmitter
    input  wire        uf_valid,
    input  wire [CH_W-1:0] uf_chan,
    input  wire        uf_pri
);

    localparam S_IDLE = 2'h0;
    localparam S_RQ   = 2'h1;
    localparam S_FQ   = 2'h2;
    localparam NENT   = 2 * NUM_CHAN;

    ////////////////////////////////////////////////////////////////////
    // Functions

    // Next index with wrap from end to start
    function [15:0] nxt;
        input [15:0] p;
        input [15:0] s;
        input [15:0] e;
        reg   [15:0] q;
        begin
            q = p + 16'h0001;
            nxt = (q == e) ? s : q;
        end
    endfunction

    // Byte-lane merge for register writes
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  sel;
        integer      i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (sel[i]) begin
                    merge[i*8 +: 8] = nw[i*8 +: 8];
                end
            end
        end
    endfunction

    // Host address of a queue element
    function [31:0] elem_addr;
        input [31:0] base;
        input [15:0] idx;
        begin
            elem_addr = {base[31:2], 2'b00} + {14'h0000, idx, 2'b00};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // State

    reg [31:0] tbase_q;
    reg [31:0] qbase_q;
    reg [15:0] rq_s_q, rq_w_q, rq_r_q, rq_e_q;
    reg [15:0] fq_s_q, fq_w_q, fq_r_q, fq_e_q;
    reg        cache_en_q;
    reg        sw_flush_q;
    reg        int_flush_q;
    reg [CH_W:0] ch_sel_q;
    reg [1:0]  state_q;
    reg [2:0]  cnt_q;
    reg [17:0] cache_q [0:CACHE_N-1];
    reg        act_q [0:NENT-1];
    reg        uf_q  [0:NENT-1];
    reg [14:0] last_ref_q [0:NENT-1];

    wire        wb_hit   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        wb_wr    = wb_hit & wb_we_i;
    wire [15:0] rq_next  = nxt(rq_r_q, rq_s_q, rq_e_q);
    wire        rq_empty = (rq_next == rq_w_q);
    // A zero end index means an unprogrammed queue: no fetch from it
    wire        rq_on    = (rq_e_q != 16'h0000);
    wire        fq_full  = (fq_r_q == fq_w_q);
    wire        take     = ret_valid & ret_ready_q;
    wire [CH_W:0] ret_idx = {ret_chan, ret_pri};
    wire [CH_W:0] uf_idx  = {uf_chan, uf_pri};
    wire        cache_full = (cnt_q == CACHE_N[2:0]);
    wire        flush_need = sw_flush_q | int_flush_q | cache_full;
    wire        ret_act  = act_q[ret_idx];
    wire [2:0]  ret_st;
    wire [17:0] ret_elem;

    // Status of a freed reference
    assign ret_st   = {uf_q[ret_idx],
                       ret_act ? ret_status : `TXDQ_ST_UNPROV};
    assign ret_elem = {ret_st, ret_descriptor_ref};

    ////////////////////////////////////////////////////////////////////
    // Wishbone register slave

    // One-cycle ack, registers, control bits
    always @(posedge core_clk) begin
        if (!reset_n) begin
            wb_ack_o   <= 1'b0;
            wb_dat_o   <= 32'h0000_0000;
            tbase_q    <= 32'h0000_0000;
            qbase_q    <= 32'h0000_0000;
            rq_s_q     <= 16'h0000;
            rq_w_q     <= 16'h0000;
            rq_e_q     <= 16'h0000;
            fq_s_q     <= 16'h0000;
            fq_r_q     <= 16'h0000;
            fq_e_q     <= 16'h0000;
            cache_en_q <= 1'b0;
            ch_sel_q   <= {(CH_W+1){1'b0}};
        end else begin
            wb_ack_o <= wb_hit;
            if (wb_wr) begin
                case (wb_adr_i)
                    `TXDQ_OFS_TBASE: tbase_q <= merge(tbase_q, wb_dat_i, wb_sel_i);
                    `TXDQ_OFS_QBASE: qbase_q <= merge(qbase_q, wb_dat_i, wb_sel_i);
                    `TXDQ_OFS_RQ_S: rq_s_q <= wb_dat_i[15:0];
                    `TXDQ_OFS_RQ_W: rq_w_q <= wb_dat_i[15:0];
                    `TXDQ_OFS_RQ_E: rq_e_q <= wb_dat_i[15:0];
                    `TXDQ_OFS_FQ_S: fq_s_q <= wb_dat_i[15:0];
                    `TXDQ_OFS_FQ_R: fq_r_q <= wb_dat_i[15:0];
                    `TXDQ_OFS_FQ_E: fq_e_q <= wb_dat_i[15:0];
                    `TXDQ_OFS_CTRL: cache_en_q <= wb_dat_i[`TXDQ_CTRL_CACHE];
                    `TXDQ_OFS_CHAN: ch_sel_q <= {wb_dat_i[CH_W-1:0], wb_dat_i[`TXDQ_CH_PRI]};
                    default: ;
                endcase
            end
            wb_dat_o <= 32'h0000_0000;
            if (wb_hit && !wb_we_i) begin
                case (wb_adr_i)
                    `TXDQ_OFS_TBASE: wb_dat_o <= tbase_q;
                    `TXDQ_OFS_QBASE: wb_dat_o <= qbase_q;
                    `TXDQ_OFS_RQ_S:  wb_dat_o <= {16'h0000, rq_s_q};
                    `TXDQ_OFS_RQ_W:  wb_dat_o <= {16'h0000, rq_w_q};
                    `TXDQ_OFS_RQ_R:  wb_dat_o <= {16'h0000, rq_r_q};
                    `TXDQ_OFS_RQ_E:  wb_dat_o <= {16'h0000, rq_e_q};
                    `TXDQ_OFS_FQ_S:  wb_dat_o <= {16'h0000, fq_s_q};
                    `TXDQ_OFS_FQ_W:  wb_dat_o <= {16'h0000, fq_w_q};
                    `TXDQ_OFS_FQ_R:  wb_dat_o <= {16'h0000, fq_r_q};
                    `TXDQ_OFS_FQ_E:  wb_dat_o <= {16'h0000, fq_e_q};
                    `TXDQ_OFS_CTRL:  wb_dat_o <= {30'h0000_0000, sw_flush_q, cache_en_q};
                    `TXDQ_OFS_STAT:  wb_dat_o <= {26'h000_0000, fq_full, rq_empty,
                                                  state_q != S_IDLE, cnt_q};
                    `TXDQ_OFS_CHAN:  wb_dat_o <= {13'h0000, uf_q[ch_sel_q], act_q[ch_sel_q],
                                                  ch_sel_q[0],
                                                  {(16-CH_W){1'b0}}, ch_sel_q[CH_W:1]};
                    default:         wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Channel table

    // Active, underflow and last-freed pointer per channel and priority
    integer k;
    always @(posedge core_clk) begin
        if (!reset_n) begin
            for (k = 0; k < NENT; k = k + 1) begin
                act_q[k]      <= 1'b0;
                uf_q[k]       <= 1'b0;
                last_ref_q[k] <= 15'h0000;
            end
        end else begin
            if (take) begin
                uf_q[ret_idx]       <= 1'b0;
                last_ref_q[ret_idx] <= ret_descriptor_ref;
            end
            if (uf_valid) begin
                uf_q[uf_idx] <= 1'b1;
            end
            if (wb_wr && wb_adr_i == `TXDQ_OFS_CHAN) begin
                act_q[{wb_dat_i[CH_W-1:0], wb_dat_i[`TXDQ_CH_PRI]}] <=
                    wb_dat_i[`TXDQ_CH_ACT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Queue engine

    // Ready fetch, free cache and free queue writes
    integer j;
    always @(posedge core_clk) begin
        if (!reset_n) begin
            state_q      <= S_IDLE;
            cnt_q        <= 3'h0;
            int_flush_q  <= 1'b0;
            sw_flush_q   <= 1'b0;
            rq_r_q       <= 16'h0000;
            fq_w_q       <= 16'h0000;
            ret_ready_q  <= 1'b0;
            rdy_valid_q  <= 1'b0;
            rdy_descriptor_ref_q     <= 15'h0000;
            rdy_descriptor_address_q <= 32'h0000_0000;
            mem_req_q    <= 1'b0;
            mem_we_q     <= 1'b0;
            mem_addr_q   <= 32'h0000_0000;
            mem_sel_q    <= 4'h0;
            mem_wdata_q  <= 32'h0000_0000;
            for (j = 0; j < CACHE_N; j = j + 1) begin
                cache_q[j] <= 18'h00000;
            end
        end else begin
            ret_ready_q <= 1'b0;
            if (rdy_valid_q && rdy_ready) begin
                rdy_valid_q <= 1'b0;
            end
            case (state_q)
                S_IDLE: begin
                    if (take) begin
                        // Every reference passes through the cache
                        cache_q[cnt_q] <= ret_elem;
                        cnt_q <= cnt_q + 3'h1;
                        if (ret_completion_notify_flag || !cache_en_q) begin
                            int_flush_q <= 1'b1;
                        end
                    end else if (flush_need) begin
                        state_q <= S_FQ;
                    end else if (rq_on && !rq_empty && !rdy_valid_q) begin
                        // Fetch next ready element
                        state_q    <= S_RQ;
                        mem_req_q  <= 1'b1;
                        mem_we_q   <= 1'b0;
                        mem_sel_q  <= `TXDQ_SEL_ALL;
                        mem_addr_q <= elem_addr(qbase_q, rq_next);
                    end else begin
                        ret_ready_q <= ~cache_full;
                    end
                end
                S_RQ: begin
                    if (mem_ack) begin
                        mem_req_q   <= 1'b0;
                        rq_r_q      <= rq_next;
                        rdy_valid_q <= 1'b1;
                        rdy_descriptor_ref_q <= mem_rdata[14:0];
                        rdy_descriptor_address_q <= {tbase_q[31:4], 4'h0}
                            + {13'h0000, mem_rdata[14:0], 4'h0};
                        state_q <= S_IDLE;
                    end
                end
                S_FQ: begin
                    if (mem_req_q) begin
                        if (mem_ack) begin
                            // Element handed over; never touched again
                            mem_req_q <= 1'b0;
                            fq_w_q    <= nxt(fq_w_q, fq_s_q, fq_e_q);
                            for (j = 0; j < CACHE_N - 1; j = j + 1) begin
                                cache_q[j] <= cache_q[j+1];
                            end
                            cnt_q <= cnt_q - 3'h1;
                        end
                    end else if (cnt_q == 3'h0) begin
                        // Drained; flush bits clear themselves
                        int_flush_q <= 1'b0;
                        sw_flush_q  <= 1'b0;
                        state_q     <= S_IDLE;
                    end else if (!fq_full) begin
                        mem_req_q   <= 1'b1;
                        mem_we_q    <= 1'b1;
                        mem_sel_q   <= `TXDQ_FREE_SEL;
                        mem_addr_q  <= elem_addr(qbase_q, fq_w_q);
                        mem_wdata_q <= {8'h00, 6'h00, cache_q[0]};
                    end
                end
                default: state_q <= S_IDLE;
            endcase
            // Software index writes override the engine
            if (wb_wr && wb_adr_i == `TXDQ_OFS_RQ_R) begin
                rq_r_q <= wb_dat_i[15:0];
            end
            if (wb_wr && wb_adr_i == `TXDQ_OFS_FQ_W) begin
                fq_w_q <= wb_dat_i[15:0];
            end
            // A software flush request wins over the self-clear
            if (wb_wr && wb_adr_i == `TXDQ_OFS_CTRL && wb_dat_i[`TXDQ_CTRL_FLUSH]) begin
                sw_flush_q <= 1'b1;
            end
        end
    end

endmodule // txdq_top
`default_nettype wire

// >>> test/txdq_props.sv
// Port-level properties of the descriptor queue manager
`timescale 1ns/1ps
`default_nettype none
module txdq_props (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        reset_n,
    // Register bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    // Host memory master
    input wire logic        mem_req_q,
    input wire logic        mem_we_q,
    input wire logic [31:0] mem_addr_q,
    input wire logic [3:0]  mem_sel_q,
    input wire logic [31:0] mem_wdata_q,
    input wire logic        mem_ack,
    // Ready references
    input wire logic        rdy_valid_q,
    input wire logic [14:0] rdy_descriptor_ref_q,
    input wire logic [31:0] rdy_descriptor_address_q,
    input wire logic        rdy_ready
);
    logic [31:0] base_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////////
    // Shadow of the table base, taken when a write is answered
    always @(posedge core_clk) begin
        if (!reset_n)
            base_q <= 32'h00000000;
        else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == 8'h00)
            base_q <= wb_dat_i;
    end
    ////////////////////////////////////////////////////////////////////////////
    property p_wb_answer; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    property p_mem_hold; mem_req_q && !mem_ack |=> mem_req_q && $stable(mem_addr_q)
        && $stable(mem_we_q) && $stable(mem_wdata_q) && $stable(mem_sel_q); endproperty
    property p_mem_release; mem_req_q && mem_ack |=> !mem_req_q; endproperty
    property p_free_fmt; mem_req_q && mem_we_q |-> mem_sel_q == 4'h7
        && mem_wdata_q[23:18] == 6'h00; endproperty
    property p_word_align; mem_req_q |-> mem_addr_q[1:0] == 2'h0; endproperty
    property p_desc_addr; rdy_valid_q |-> rdy_descriptor_address_q
        == {base_q[31:4], 4'h0} + {13'h0000, rdy_descriptor_ref_q, 4'h0}; endproperty
    property p_rdy_hold; rdy_valid_q && !rdy_ready |=> rdy_valid_q
        && $stable(rdy_descriptor_ref_q); endproperty
    a_wb_answer: assert property (p_wb_answer)
        else $error("bus access not answered");
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    a_mem_hold: assert property (p_mem_hold)
        else $error("memory request changed before answer");
    a_mem_release: assert property (p_mem_release)
        else $error("memory request kept after answer");
    a_free_fmt: assert property (p_free_fmt)
        else $error("free element lanes or zero field wrong");
    a_word_align: assert property (p_word_align)
        else $error("element address not word aligned");
    a_desc_addr: assert property (p_desc_addr)
        else $error("descriptor address wrong");
    a_rdy_hold: assert property (p_rdy_hold)
        else $error("ready reference dropped early");
    c_wb_read: cover property (wb_ack_o && !wb_we_i);
    c_free_write: cover property (mem_req_q && mem_we_q && mem_ack);
    c_rdy_take: cover property (rdy_valid_q && rdy_ready);
endmodule // txdq_props
bind txdq_top txdq_props u_props (.*);
`default_nettype wire

// >>> test/txdq_hmem.sv
// Host memory model answering the queue manager
`timescale 1ns/1ps
`default_nettype none
module txdq_hmem (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // Request from the device
    input  wire logic        mem_req_q,
    input  wire logic        mem_we_q,
    input  wire logic [31:0] mem_addr_q,
    input  wire logic [3:0]  mem_sel_q,
    input  wire logic [31:0] mem_wdata_q,
    // Answer
    output var  logic        mem_ack,
    output var  logic [31:0] mem_rdata
);
    logic [31:0] m [logic [31:0]];
    logic [31:0] w;
    logic [1:0]  wait_q;
    logic        slow_q;
    // Queues and descriptors live here; answers alternate prompt and slow
    always @(posedge core_clk) begin
        if (!reset_n) begin
            mem_ack <= 1'b0;
            mem_rdata <= 32'h5A5A5A5A;
            wait_q <= 2'h0;
            slow_q <= 1'b0;
        end else if (mem_req_q && !mem_ack && wait_q != 2'h0) begin
            wait_q <= wait_q - 2'h1;
        end else if (mem_req_q && !mem_ack) begin
            w = m.exists(mem_addr_q) ? m[mem_addr_q] : 32'h00000000;
            for (int b = 0; b < 4; b++)
                if (mem_we_q && mem_sel_q[b])
                    w[8*b +: 8] = mem_wdata_q[8*b +: 8];
            m[mem_addr_q] = w;
            mem_ack <= 1'b1;
            mem_rdata <= w;
            wait_q <= slow_q ? 2'h3 : 2'h0;
            slow_q <= ~slow_q;
        end else begin
            // Released data lines do not keep the last value
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule // txdq_hmem
`default_nettype wire

// >>> test/tb.sv
// Self-checking bench of the descriptor queue manager
`timescale 1ns/1ps
`default_nettype none
`include "txdq_consts.vh"
module tb;
    logic core_clk = 0, reset_n = 0, go = 0;
    logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
    logic [7:0]  wb_adr_i = 0;
    logic [3:0]  wb_sel_i = 4'hF, mem_sel_q;
    logic [31:0] wb_dat_i = 0, wb_dat_o, mem_addr_q, mem_wdata_q, mem_rdata;
    logic mem_req_q, mem_we_q, mem_ack, rdy_valid_q, rdy_ready = 0;
    logic [31:0] rdy_descriptor_address_q, seed = 32'h0000ADDB, tb_base, q_base, rd;
    logic [14:0] rdy_descriptor_ref_q, ret_descriptor_ref = 0, r;
    logic ret_valid = 0, ret_pri = 0, ret_completion_notify_flag = 0, ret_ready_q;
    logic [1:0]  ret_status = 0;
    logic [9:0]  ret_chan = 0, uf_chan = 0;
    logic uf_valid = 0, uf_pri = 0;
    logic [15:0] fw = 16'h0020;
    logic [63:0] exp_rdy[$], exp_free[$];
    int n_fail = 0, n_checks = 0;
    txdq_top DUT (.*);
    txdq_hmem u_mem (.*);
    always #2.5 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string s);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, s, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Classic single Wishbone cycle; read data lands in rd
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= we; wb_adr_i <= a; wb_dat_i <= d;
        @(posedge core_clk iff wb_ack_o === 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
    endtask
    // Return one reference and note the free element it must become
    task automatic ret(input logic [1:0] st, input logic [9:0] ch, input logic nf,
                       input logic [2:0] xs);
        rd = rnd();
        @(posedge core_clk);
        ret_valid <= 1; ret_descriptor_ref <= rd[14:0]; ret_status <= st;
        ret_chan <= ch; ret_pri <= 1; ret_completion_notify_flag <= nf;
        @(posedge core_clk iff ret_ready_q === 1'b1);
        ret_valid <= 0;
        exp_free.push_back({q_base + {fw, 2'h0}, 8'h70, 6'h00, xs, rd[14:0]});
        fw = (fw == 16'h0027) ? 16'h0020 : fw + 16'h0001;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Result watcher: oldest note against each observed result
    always @(posedge core_clk) begin
        if ((mem_req_q & mem_ack & mem_we_q) === 1'b1)
            chk({mem_addr_q, mem_sel_q, 4'h0, mem_wdata_q[23:0]}, exp_free.pop_front(), "free");
        if ((rdy_valid_q & rdy_ready) === 1'b1)
            chk({rdy_descriptor_address_q, 17'h0, rdy_descriptor_ref_q}, exp_rdy.pop_front(), "rdy");
    end
    // Consumer of ready references stalls every other cycle
    always @(posedge core_clk) rdy_ready <= go & ~rdy_ready;
    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        end_of_test();
    end
    initial begin
        repeat (10) @(posedge core_clk);
        reset_n <= 1;
        for (int a = 0; a <= 40; a += 4) begin
            wb(0, a[7:0], 0);
            chk(rd, 0, "reset");
        end
        wb(0, 8'h3C, 32'hFFFFFFFF);
        chk(rd, 0, "unmapped");
        tb_base = rnd() & 32'hFFFFFFF0;
        q_base = rnd() & 32'hFFFFFFFC;
        for (int i = 32; i < 40; i++) u_mem.m[q_base + 4*i] = 32'hA5000000;
        for (int i = 0; i < 2; i++) begin
            rd = rnd();
            r = (i == 1) ? 15'h7FFF : rd[14:0];
            u_mem.m[q_base + 32'h40 + 4*i] = {rd[31:15], r};
            exp_rdy.push_back({tb_base + {13'h0000, r, 4'h0}, 17'h0, r});
        end
        wb(1, `TXDQ_OFS_TBASE, tb_base);
        wb(0, `TXDQ_OFS_TBASE, 0);
        chk(rd, tb_base, "base");
        wb(1, `TXDQ_OFS_QBASE, q_base);
        // Empty queues: read one below end, write at start
        wb(1, `TXDQ_OFS_RQ_S, 32'h10);
        wb(1, `TXDQ_OFS_RQ_W, 32'h10);
        wb(1, `TXDQ_OFS_RQ_R, 32'h13);
        wb(1, `TXDQ_OFS_RQ_E, 32'h14);
        wb(1, `TXDQ_OFS_FQ_S, 32'h20);
        wb(1, `TXDQ_OFS_FQ_E, 32'h28);
        wb(1, `TXDQ_OFS_FQ_R, 32'h27);
        wb(1, `TXDQ_OFS_FQ_W, 32'h20);
        go = 1;
        wb(1, `TXDQ_OFS_RQ_W, 32'h12);
        wait (exp_rdy.size() == 0);
        repeat (4) @(posedge core_clk);
        wb(0, `TXDQ_OFS_RQ_R, 0);
        chk(rd, 32'h11, "ready read index");
        wb(1, `TXDQ_OFS_CHAN, 32'h00030005);
        wb(1, `TXDQ_OFS_CTRL, 32'h1);
        repeat (2) begin
            @(posedge core_clk);
            uf_valid <= 1; uf_chan <= 5; uf_pri <= 1;
            @(posedge core_clk);
            uf_valid <= 0;
        end
        wb(0, `TXDQ_OFS_CHAN, 0);
        chk(rd[18:17], 2'h3, "entry flags");
        ret(2'h1, 5, 0, 3'h5);
        ret(2'h0, 5, 0, 3'h0);
        ret(2'h0, 7, 0, 3'h2);
        ret(2'h3, 5, 0, 3'h3);
        ret(2'h0, 5, 0, 3'h0);
        repeat (20) @(posedge core_clk);
        chk(exp_free.size(), 5, "cached");
        ret(2'h0, 5, 0, 3'h0);
        wait (exp_free.size() == 0);
        ret(2'h0, 5, 1, 3'h0);
        wait (exp_free.size() == 0);
        ret(2'h1, 5, 0, 3'h1);
        wb(1, `TXDQ_OFS_CTRL, 32'h3);
        repeat (20) @(posedge core_clk);
        chk(exp_free.size(), 1, "held while full");
        wb(1, `TXDQ_OFS_FQ_R, 32'h26);
        wait (exp_free.size() == 0);
        repeat (4) @(posedge core_clk);
        wb(0, `TXDQ_OFS_FQ_W, 0);
        chk(rd, 32'h20, "free write wrap");
        wb(0, `TXDQ_OFS_CTRL, 0);
        chk(rd[1:0], 2'h1, "flush cleared");
        for (int i = 32; i < 40; i++)
            chk(u_mem.m[q_base + 4*i][31:24], 8'hA5, "upper lanes");
        end_of_test();
    end
endmodule // tb
`default_nettype wire
